// file: dv/tb.sv
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // signals and instance
    // ----------------------------------------
    logic       mclk, sys_rst, cpu_wr, cpu_rd, sel_clr, sel_mode, bitop;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ovf, rst_req, nmi_req, running;
    int         err_total, n_tests, ovf_n, rst_n, nmi_n;

    // short intervals: 2^(1+sel) cycles
    wdf_top #(.CNT_W(17), .MIN_EXP(1)) wdf_top_i (
        .MCLK(mclk), .SYS_RST(sys_rst), .CPU_WR(cpu_wr), .CPU_RD(cpu_rd),
        .CPU_SEL_CLEAR(sel_clr), .CPU_SEL_MODE(sel_mode), .CPU_BITOP(bitop),
        .CPU_WDATA(wdata), .CPU_RDATA(rdata), .WDT_OVF(ovf),
        .WDT_RST_REQ(rst_req), .WDT_NMI_REQ(nmi_req), .WDT_RUNNING(running));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // pulse tally, taken just after each edge once the outputs have settled
    always @(posedge mclk) begin
        #1;
        ovf_n += (ovf === 1'b1);
        rst_n += (rst_req === 1'b1);
        nmi_n += (nmi_req === 1'b1);
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        {cpu_wr, cpu_rd, sel_clr, sel_mode, bitop, wdata} = '0;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        {ovf_n, rst_n, nmi_n} = '0;
    endtask

    // one access, one-cycle strobe, released a cycle later
    task automatic acc(input logic wr, rd, sc, sm, bo, input logic [7:0] d);
        @(negedge mclk);
        {cpu_wr, cpu_rd, sel_clr, sel_mode, bitop, wdata} = {wr, rd, sc, sm, bo, d};
        @(negedge mclk);
        {cpu_wr, cpu_rd, sel_clr, sel_mode, bitop} = '0;
    endtask

    // watch n cycles, compare pulse counts, then start afresh
    task automatic pulses(input int n, eo, er, en);
        repeat (n) @(negedge mclk);
        `CHK("ovf_pulses", eo, ovf_n)
        `CHK("rst_pulses", er, rst_n)
        `CHK("nmi_pulses", en, nmi_n)
        {ovf_n, rst_n, nmi_n} = '0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_autostart();
        int c;
        do_reset();
        `CHK("running_reset", 1'b1, running)
        c = 0;
        while (ovf_n == 0 && c < 70000) begin
            @(negedge mclk);
            c++;
        end
        if (c >= 70000) begin
            $display("ERROR ovf_wait expected %0d seen %0d", 65536, c);
            err_total++;
            wrap_up();
        end
        `CHK("timeout_cycles", 1'b1, (c > 65530 && c < 65545))
        pulses(1, 1, 1, 0);
    endtask

    task automatic t_wrong_key();
        logic [7:0] bad [5] = '{8'h00, 8'h55, 8'hab, 8'had, 8'hff};
        do_reset();
        foreach (bad[i]) begin
            acc(1, 0, 1, 0, 0, bad[i]);
            pulses(3, 1, 1, 0);
        end
        acc(1, 0, 1, 0, 1, 8'hac); // bit op even with the key is refused
        pulses(3, 1, 1, 0);
    endtask

    task automatic t_key_restart();
        do_reset();
        acc(1, 0, 0, 1, 0, 8'h02); // interrupt mode, 8-cycle interval
        repeat (8) acc(1, 0, 1, 0, 0, 8'hac);
        pulses(1, 0, 0, 0);
        pulses(12, 1, 0, 1);
    endtask

    task automatic t_readback();
        do_reset();
        acc(1, 0, 1, 0, 0, 8'hac);
        acc(0, 1, 1, 0, 0, 8'h00);
        `CHK("clear_read", 8'h9a, rdata)
        acc(1, 0, 0, 1, 0, 8'h05);
        acc(0, 1, 0, 1, 0, 8'h00);
        `CHK("mode_read", 8'h05, rdata)
        acc(0, 1, 1, 0, 0, 8'h00);
        `CHK("clear_read2", 8'h9a, rdata)
    endtask

    task automatic t_mode_twice();
        do_reset();
        acc(1, 0, 0, 1, 0, 8'h4e);
        pulses(3, 0, 0, 0);
        acc(1, 0, 0, 1, 0, 8'h0e);
        pulses(3, 1, 1, 0);
        acc(0, 1, 0, 1, 0, 8'h00);
        `CHK("mode_kept", 8'h4e, rdata)
    endtask

    task automatic t_stopped();
        do_reset();
        acc(1, 0, 0, 1, 0, 8'h1f);
        pulses(3, 0, 0, 0);
        `CHK("running_stop", 1'b0, running)
        acc(1, 0, 0, 1, 0, 8'h0f);
        acc(1, 0, 1, 0, 0, 8'h55);
        acc(1, 0, 1, 0, 1, 8'hac);
        pulses(40, 0, 0, 0);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        err_total = 0;
        n_tests   = 0;
        t_autostart();
        t_wrong_key();
        t_key_restart();
        t_readback();
        t_mode_twice();
        t_stopped();
        wrap_up();
    end
endmodule // tb

// file: rtl/wdf_counter.sv
`include "wdf_defs.svh"
module wdf_counter
    import wdf_pkg::*;
#(
    parameter int CNT_W   = `WDF_CNT_W_DEF,
    parameter int MIN_EXP = `WDF_MIN_EXP_DEF
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // control
    input  wire logic             run,
    input  wire logic             clr,
    input  wire logic [3:0]       sel,
    // state
    output logic      [CNT_W-1:0] count,
    output logic                  terminal
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] limit;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (CNT_W < MIN_EXP + 16 || MIN_EXP < 1) begin : g_bad_width
        $error("counter too narrow for the interval selection");
    end

    // last count of the selected interval, 2^(MIN_EXP+sel) cycles
    assign limit    = (CNT_W'(1) << (MIN_EXP + int'(sel))) - CNT_W'(1);
    assign terminal = run && (count_reg == limit);
    assign count    = count_reg;

    // next count: clear wins, wrap at terminal, hold when stopped
    always_comb begin
        count_next = count_reg;
        if (clr || terminal) begin
            count_next = '0;
        end else if (run) begin
            count_next = count_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // wdf_counter

// file: rtl/wdf_defs.svh
`ifndef WDF_DEFS_SVH
`define WDF_DEFS_SVH

// ----------------------------------------
// register values
// ----------------------------------------
`define WDF_CLEAR_KEY      8'hac
`define WDF_CLEAR_READBACK 8'h9a
`define WDF_MODE_STOP      8'h1f
`define WDF_MODE_RESET_VAL 8'h4f
`define WDF_READ_NONE      8'h00

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define WDF_MODE_RSTSEL_BIT 6
`define WDF_MODE_SEL_HI     3
`define WDF_MODE_SEL_LO     0

// ----------------------------------------
// timing
// ----------------------------------------
`define WDF_MIN_EXP_DEF 10
`define WDF_CNT_W_DEF   26
`endif

// file: rtl/wdf_pkg.sv
package wdf_pkg;
    // configuration state of the watchdog
    typedef enum logic [1:0] {
        WDF_FRESH   = 2'b00,
        WDF_SET     = 2'b01,
        WDF_STOPPED = 2'b10
    } wdf_state_e;
endpackage : wdf_pkg

// file: rtl/wdf_top.sv
`include "wdf_defs.svh"
module wdf_top
    import wdf_pkg::*;
#(
    parameter int CNT_W   = `WDF_CNT_W_DEF,
    parameter int MIN_EXP = `WDF_MIN_EXP_DEF
) (
    // clock and reset
    input  wire logic       MCLK,
    input  wire logic       SYS_RST,
    // processor access
    input  wire logic       CPU_WR,
    input  wire logic       CPU_RD,
    input  wire logic       CPU_SEL_CLEAR,
    input  wire logic       CPU_SEL_MODE,
    input  wire logic       CPU_BITOP,
    input  wire logic [7:0] CPU_WDATA,
    output logic      [7:0] CPU_RDATA,
    // watchdog outputs
    output logic            WDT_OVF,
    output logic            WDT_RST_REQ,
    output logic            WDT_NMI_REQ,
    output logic            WDT_RUNNING
);
    wdf_state_e       state_reg;
    wdf_state_e       state_next;
    logic [7:0]       mode_reg;
    logic [7:0]       mode_next;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;
    logic             ovf_reg;
    logic             ovf_next;
    logic             rst_req_reg;
    logic             rst_req_next;
    logic             nmi_req_reg;
    logic             nmi_req_next;
    logic             stopped;
    logic             clr_wr;
    logic             mode_wr;
    logic             key_ok;
    logic             force_ovf;
    logic             mode_take;
    logic             restart;
    logic             rst_sel;
    logic             terminal;
    logic [CNT_W-1:0] count;

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    assign stopped = (state_reg == WDF_STOPPED);
    assign clr_wr  = CPU_WR && CPU_SEL_CLEAR;
    assign mode_wr = CPU_WR && CPU_SEL_MODE;
    // a bit manipulation never counts as a clear, even with the key
    assign key_ok  = clr_wr && !CPU_BITOP && (CPU_WDATA == `WDF_CLEAR_KEY);
    // forced overflow sources, all masked while stopped
    assign force_ovf = !stopped && ((clr_wr && !key_ok)
                                 || (mode_wr && state_reg == WDF_SET));
    // the accepted mode write starts the new interval from zero, so a
    // shorter interval never finds the count already past its end
    assign mode_take = mode_wr && (state_reg == WDF_FRESH);
    assign restart   = key_ok || force_ovf || mode_take;
    assign rst_sel   = mode_reg[`WDF_MODE_RSTSEL_BIT];

    // ----------------------------------------
    // interval counter
    // ----------------------------------------
    wdf_counter #(
        .CNT_W   (CNT_W),
        .MIN_EXP (MIN_EXP)
    ) u_counter (
        .clk      (MCLK),
        .rst      (SYS_RST),
        .run      (!stopped),
        .clr      (restart),
        .sel      (mode_reg[`WDF_MODE_SEL_HI:`WDF_MODE_SEL_LO]),
        .count    (count),
        .terminal (terminal)
    );

    // ----------------------------------------
    // mode register and configuration state
    // ----------------------------------------
    // only the first write after reset lands; stop is final until reset
    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        case (state_reg)
            WDF_FRESH: begin
                if (mode_wr) begin
                    mode_next  = CPU_WDATA;
                    state_next = (CPU_WDATA == `WDF_MODE_STOP) ? WDF_STOPPED : WDF_SET;
                end
            end
            WDF_SET:     state_next = WDF_SET;
            WDF_STOPPED: state_next = WDF_STOPPED;
            default:     state_next = WDF_FRESH;
        endcase
    end

    // configuration registers, back to the self-starting setting on reset
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= WDF_FRESH;
            mode_reg  <= `WDF_MODE_RESET_VAL;
        end else begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
        end
    end

    // ----------------------------------------
    // read data and overflow outputs
    // ----------------------------------------
    // clear register reads a fixed pattern so a read-back can never feed the key
    always_comb begin
        rdata_next   = rdata_reg;
        // a key written in the last count cancels that interval's timeout
        ovf_next     = force_ovf || (terminal && !key_ok);
        rst_req_next = ovf_next && mode_reg[`WDF_MODE_RSTSEL_BIT];
        nmi_req_next = ovf_next && !mode_reg[`WDF_MODE_RSTSEL_BIT];
        if (CPU_RD && CPU_SEL_CLEAR) begin
            rdata_next = `WDF_CLEAR_READBACK;
        end else if (CPU_RD && CPU_SEL_MODE) begin
            rdata_next = mode_reg;
        end else if (CPU_RD) begin
            rdata_next = `WDF_READ_NONE;
        end
    end

    // output flops, so each pulse lasts one whole clock per cycle its source is high
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_reg   <= `WDF_READ_NONE;
            ovf_reg     <= 1'b0;
            rst_req_reg <= 1'b0;
            nmi_req_reg <= 1'b0;
        end else begin
            rdata_reg   <= rdata_next;
            ovf_reg     <= ovf_next;
            rst_req_reg <= rst_req_next;
            nmi_req_reg <= nmi_req_next;
        end
    end

    assign CPU_RDATA   = rdata_reg;
    assign WDT_OVF     = ovf_reg;
    assign WDT_RST_REQ = rst_req_reg;
    assign WDT_NMI_REQ = nmi_req_reg;
    assign WDT_RUNNING = !stopped;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence s_wrong_key;
        clr_wr && !CPU_BITOP && CPU_WDATA != `WDF_CLEAR_KEY && !stopped;
    endsequence
    sequence s_second_mode;
        mode_wr && state_reg == WDF_SET;
    endsequence
    sequence s_stop_write;
        mode_wr && state_reg == WDF_FRESH && CPU_WDATA == `WDF_MODE_STOP;
    endsequence
    sequence s_ovf_restart;
        WDT_OVF && count == '0;
    endsequence

    wrong_key_a: assert property (s_wrong_key |=> WDT_OVF)
        else $error("wrong key did not force overflow");
    bit_op_a: assert property (clr_wr && CPU_BITOP && !stopped |=> WDT_OVF)
        else $error("bit manipulation did not force overflow");
    read_value_a: assert property (CPU_RD && CPU_SEL_CLEAR |=> CPU_RDATA == `WDF_CLEAR_READBACK)
        else $error("clear register read back wrong value");
    second_mode_a: assert property (s_second_mode |=> WDT_OVF && mode_reg == $past(mode_reg))
        else $error("second mode write not forced");
    stopped_quiet_a: assert property (stopped && $past(stopped) |-> !WDT_OVF)
        else $error("overflow while stopped");
    auto_start_a: assert property (state_reg == WDF_FRESH |-> mode_reg == `WDF_MODE_RESET_VAL && WDT_RUNNING)
        else $error("watchdog not running in reset mode");
    stop_write_a: assert property (s_stop_write |=> !WDT_RUNNING ##1 $stable(count) [*3])
        else $error("stop value did not halt count");
    key_restart_a: assert property (key_ok |=> count == '0 && !WDT_OVF)
        else $error("key did not restart count");
    ovf_route_a: assert property (WDT_OVF |-> WDT_RST_REQ != WDT_NMI_REQ)
        else $error("overflow not routed to one request");

    // until the first mode write the count climbs by one each cycle it does not wrap or restart
    fresh_count_a: assert property (state_reg == WDF_FRESH && !terminal && !restart
        |=> count == $past(count) + CNT_W'(1))
        else $error("count did not advance after reset");
    // a finished interval gives one overflow and a fresh count
    timeout_a: assert property (terminal && !key_ok |=> s_ovf_restart)
        else $error("interval end gave no overflow");
    // every forced overflow also restarts the count
    force_clear_a: assert property (force_ovf |=> s_ovf_restart)
        else $error("forced overflow did not restart count");
    // the first mode write is the one that lands
    first_mode_a: assert property (mode_take |=>
        mode_reg == $past(CPU_WDATA) && state_reg != WDF_FRESH)
        else $error("first mode write not taken");
    // a taken setting stays until reset
    set_final_a: assert property (state_reg == WDF_SET |=> state_reg == WDF_SET)
        else $error("mode setting left its state");
    stop_final_a: assert property (stopped |=> stopped)
        else $error("stopped watchdog restarted");
    // the count is frozen while stopped, a key write only zeroes it
    stop_frozen_a: assert property (stopped && !key_ok |=> $stable(count))
        else $error("count moved while stopped");
    // routing follows the mode bit seen when the overflow was raised
    route_mode_a: assert property (WDT_OVF |-> WDT_RST_REQ == $past(rst_sel))
        else $error("overflow routed against mode");
    // mode register reads back what was stored
    read_mode_a: assert property (CPU_RD && CPU_SEL_MODE && !CPU_SEL_CLEAR
        |=> CPU_RDATA == $past(mode_reg))
        else $error("mode read back wrong value");
    unsel_read_a: assert property (CPU_RD && !CPU_SEL_CLEAR && !CPU_SEL_MODE
        |=> CPU_RDATA == `WDF_READ_NONE)
        else $error("unselected read not zero");
    // read data holds between reads
    rdata_hold_a: assert property (!CPU_RD |=> $stable(CPU_RDATA))
        else $error("read data changed without a read");
endmodule // wdf_top
